// File: design/usg_cnt_if.sv
// link between the strobe control logic and the period down-counter
`timescale 1ns/100ps
interface usg_cnt_if;
  import usg_pkg::*;
  usg_word_t period;
  logic run;
  logic fire;
  modport gen (input period, input run, output fire);
  modport ctl (output period, output run, input fire);
endinterface : usg_cnt_if

// File: design/usg_params.svh
// register map, field positions, reset values and pulse timing of the update strobe generator
`ifndef USG_PARAMS_SVH
`define USG_PARAMS_SVH
`define USG_IDX_W 6
`define USG_PERIOD_IDX 6'h16
`define USG_CTRL_IDX 6'h1f
`define USG_STAT_IDX 6'h30
`define USG_CTRL_INT_BIT 0
`define USG_STAT_PIN_BIT 0
`define USG_STAT_INT_BIT 1
`define USG_STAT_CNT_LSB 16
`define USG_PERIOD_RST 32'h0000_00ff
`define USG_CTRL_RST 32'h0000_0001
`define USG_PULSE_CYC 4'h8
`endif

// File: design/usg_period_gen.sv
// period down-counter running at half the system clock rate
`timescale 1ns/100ps
`include "usg_params.svh"
module usg_period_gen
  import usg_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // counter link
  usg_cnt_if.gen cnt
);
  usg_word_t cnt_q, cnt_d;
  logic phase_q, phase_d;
  logic fire_q, fire_d;

  // each count value lasts two system clocks, so a period is 2*(n+1) cycles
  always_comb begin
    cnt_d = cnt_q;
    phase_d = 1'b0;
    fire_d = 1'b0;
    if (!cnt.run) begin
      cnt_d = cnt.period;
    end else begin
      phase_d = ~phase_q;
      if (phase_q) begin
        if (cnt_q == 32'h0000_0000) begin
          fire_d = 1'b1;
          cnt_d = cnt.period;
        end else begin
          cnt_d = cnt_q - 32'h0000_0001;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= `USG_PERIOD_RST;
      phase_q <= 1'b0;
      fire_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      phase_q <= phase_d;
      fire_q <= fire_d;
    end
  end

  assign cnt.fire = fire_q;
endmodule : usg_period_gen

// File: design/usg_pkg.sv
// types shared by the update strobe generator modules
package usg_pkg;
  typedef logic [31:0] usg_word_t;
  typedef logic [3:0] usg_hold_t;
  typedef logic [15:0] usg_evcnt_t;
endpackage : usg_pkg

// File: design/usg_top.sv
// update strobe generator: wishbone registers, internal/external strobe, core update
// Function
// - core update happens only on a rising update strobe edge, pin or counter.
// - external strobe passes a two-flop synchroniser before any use.
// - internal mode is the default; clearing the select bit picks external mode.
// - counter runs at half system clock, updates when it reaches zero.
// - internal updates are spaced (period+1) times two system clocks.
// - each internal pulse on the strobe pin stays high eight system clocks.
// - internal strobe drives both the core update and the strobe pin.
// - active-high master reset returns all registers to their defaults.
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/100ps
`include "usg_params.svh"
module usg_top
  import usg_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic master_reset,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // update strobe pin
  input wire logic strobe_i,
  output logic strobe_o,
  output logic strobe_oe,
  // core transfer
  output logic core_update
);
  usg_cnt_if cnt ();

  usg_period_gen u_gen (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cnt(cnt)
  );

  // synchronisers for the pin and the master reset
  logic pin_s1_q, pin_s2_q, pin_s3_q;
  logic mr_s1_q, mr_s2_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      mr_s1_q <= 1'b0;
      mr_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= strobe_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      mr_s1_q <= master_reset;
      mr_s2_q <= mr_s1_q;
    end
  end

  // register file
  usg_word_t period_q, period_d;
  logic int_q, int_d;
  usg_evcnt_t evcnt_q, evcnt_d;
  logic ack_q, ack_d;
  usg_word_t rdat_q, rdat_d;
  logic [31:0] wmask;
  logic [`USG_IDX_W-1:0] idx;
  logic wr_now;
  localparam usg_word_t ctrl_rst = `USG_CTRL_RST;

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b+7:8*b] = {8{wb_sel_i[b]}};
    end
  endgenerate

  assign idx = wb_adr_i[7:2];
  // the write lands on the edge where the master sees ack
  assign wr_now = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;

  always_comb begin
    period_d = period_q;
    int_d = int_q;
    evcnt_d = evcnt_q;
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d = 32'h0000_0000;
    if (core_update) begin
      evcnt_d = evcnt_q + 16'h0001;
    end
    if (wr_now && idx == `USG_PERIOD_IDX) begin
      period_d = (period_q & ~wmask) | (wb_dat_i & wmask);
    end
    if (wr_now && idx == `USG_CTRL_IDX && wb_sel_i[0]) begin
      int_d = wb_dat_i[`USG_CTRL_INT_BIT];
    end
    if (ack_d) begin
      unique case (idx)
        `USG_PERIOD_IDX: rdat_d = period_q;
        `USG_CTRL_IDX: rdat_d[`USG_CTRL_INT_BIT] = int_q;
        `USG_STAT_IDX: begin
          rdat_d[`USG_STAT_PIN_BIT] = pin_s2_q;
          rdat_d[`USG_STAT_INT_BIT] = int_q;
          rdat_d[31:`USG_STAT_CNT_LSB] = evcnt_q;
        end
        default: rdat_d = 32'h0000_0000;
      endcase
    end
    if (mr_s2_q) begin
      period_d = `USG_PERIOD_RST;
      int_d = ctrl_rst[`USG_CTRL_INT_BIT];
      evcnt_d = 16'h0000;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_q <= `USG_PERIOD_RST;
      int_q <= ctrl_rst[`USG_CTRL_INT_BIT];
      evcnt_q <= 16'h0000;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      period_q <= period_d;
      int_q <= int_d;
      evcnt_q <= evcnt_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign cnt.period = period_q;
  assign cnt.run = int_q && !mr_s2_q;

  // strobe pin and core update
  usg_hold_t hold_q, hold_d;
  logic strobe_q, strobe_d, oe_q, oe_d, upd_q, upd_d;
  logic ext_edge;
  assign ext_edge = pin_s2_q && !pin_s3_q;

  always_comb begin
    hold_d = (hold_q != 4'h0) ? hold_q - 4'h1 : 4'h0;
    if (cnt.fire) begin
      hold_d = `USG_PULSE_CYC;
    end
    strobe_d = int_q && (hold_d != 4'h0);
    oe_d = int_q;
    upd_d = int_q ? cnt.fire : ext_edge;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= 4'h0;
      strobe_q <= 1'b0;
      oe_q <= 1'b0;
      upd_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      strobe_q <= strobe_d;
      oe_q <= oe_d;
      upd_q <= upd_d;
    end
  end

  assign strobe_o = strobe_q;
  assign strobe_oe = oe_q;
  assign core_update = upd_q;

  // helper: cycles between internal fires and the period loaded at the last reload
  logic [33:0] gap_q;
  usg_word_t per_q, ref_q;
  logic armed_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 34'h0;
      per_q <= 32'h0000_0000;
      ref_q <= 32'h0000_0000;
      armed_q <= 1'b0;
    end else begin
      gap_q <= cnt.fire ? 34'h1 : gap_q + 34'h1;
      // the reload sits on the same edge that raises the registered fire, one edge before ref_q samples it
      per_q <= period_q;
      ref_q <= cnt.fire ? per_q : ref_q;
      armed_q <= cnt.run && (cnt.fire || armed_q);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_pulse_high: assert property ($rose(strobe_o) |-> strobe_o [*8])
    else $error("strobe pulse shorter than eight cycles");
  a_pin_release: assert property (!strobe_oe |-> !strobe_o)
    else $error("strobe driven while pin is an input");
  a_master_defaults: assert property (mr_s2_q |=> int_q && period_q == `USG_PERIOD_RST)
    else $error("master reset left registers off default");
  a_ext_edge_sync: assert property ((core_update && !$past(int_q)) |->
      $past(pin_s2_q) && !$past(pin_s3_q))
    else $error("external update without synchronised rising edge");
  a_int_fire_update: assert property ((cnt.fire && int_q) |=> core_update && strobe_o)
    else $error("internal fire did not update core and pin");
  a_period_gap: assert property ((cnt.fire && armed_q) |->
      gap_q == {{1'b0, ref_q} + 33'h1, 1'b0})
    else $error("internal update spacing wrong");
  a_update_cause: assert property (core_update |->
      ($past(int_q) && $past(cnt.fire)) || (!$past(int_q) && $past(ext_edge)))
    else $error("core update without a strobe edge");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_latency: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack not given one cycle after the request");

  c_int_update: cover property (int_q && core_update);
  c_ext_update: cover property (!int_q && core_update);
  c_mode_switch: cover property ($fell(int_q) ##[1:20] core_update);
  c_master_init: cover property (mr_s2_q ##1 !mr_s2_q);
  c_ext_pin_held: cover property ((!int_q && pin_s2_q) [*8]);
endmodule : usg_top

// File: tb/tb.sv
// self-checking bench of the update strobe generator
`timescale 1ns/100ps
`include "usg_params.svh"
module tb;
  import usg_pkg::*;
  logic sys_clk = 0, rst_n = 0, master_reset = 0, go = 0;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h00, hold = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [31:0] seed = 32'h0001_4e10;
  logic wb_ack_o, strobe_i, strobe_o, strobe_oe, core_update;
  int num_errors = 0, cmp_count = 0, nup = 0, hi = 0, hilen = 0, t = 0;
  // model: update times seen and the strobe mode that software selected
  int upd_t[$];
  logic md = 1'b1;
  int n, c;
  always #50 sys_clk = ~sys_clk;
  usg_top u_usg_top (.sys_clk, .rst_n, .master_reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .strobe_i, .strobe_o,
    .strobe_oe, .core_update);
  usg_host_model u_usg_host_model (.sys_clk, .strobe_oe, .strobe_o, .hold, .go,
    .pin(strobe_i));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // period gap, pin high time and update count seen at the ports
  always @(posedge sys_clk) begin
    t <= t + 1;
    if (core_update === 1'b1) begin
      nup <= nup + 1;
      upd_t.push_back(t);
      check("pin at update", strobe_o, md);
    end
    if (strobe_o === 1'b1) hi <= hi + 1;
    else if (hi > 0) begin
      hilen <= hi;
      hi <= 0;
    end
  end
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    @(posedge sys_clk);
    while (wb_ack_o !== 1'b1 && k < 50) begin
      @(posedge sys_clk);
      k++;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge sys_clk);
    if (k == 50) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : wb
  task automatic wait_up(input int k);
    c = nup + k;
    for (int i = 0; i < 2000 && nup < c; i++) @(posedge sys_clk);
    if (nup < c) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : wait_up
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1;
    @(posedge sys_clk);
    wb(0, 8'h58, 32'h0);
    check("period", rd, `USG_PERIOD_RST);
    wb(0, 8'h7c, 32'h0);
    check("ctrl", rd, 32'h1);
    check("oe", strobe_oe, 32'h1);
    wb(0, 8'h04, 32'h0);
    check("unmapped", rd, 32'h0);
    for (int i = 0; i < 3; i++) begin
      n = 4 + int'(rnd() % 16);
      wb(1, 8'h58, n);
      wait_up(3);
      check("gap", upd_t[$] - upd_t[$-1], 2 * (n + 1));
      check("gap before", upd_t[$-1] - upd_t[$-2], 2 * (n + 1));
      check("high", hilen, 8);
    end
    // a long period keeps the next pulse clear of the mode switch
    wb(1, 8'h58, 32'h40);
    wait_up(1);
    repeat (10) @(posedge sys_clk);
    wb(1, 8'h7c, 32'h0);
    md <= 1'b0;
    @(posedge sys_clk);
    check("oe ext", strobe_oe, 32'h0);
    c = nup;
    hold <= 8'h28;
    go <= 1;
    @(posedge sys_clk);
    go <= 0;
    // the host holds the pin high for 40 cycles, then low again
    repeat (60) @(posedge sys_clk);
    check("ext updates", nup - c, 1);
    wb(0, 8'hc0, 32'h0);
    check("status", rd[1:0], 2'b00);
    check("update count", rd[31:16], nup[15:0]);
    wb(1, 8'h58, rnd() | 32'h1);
    master_reset <= 1;
    md <= 1'b1;
    repeat (4) @(posedge sys_clk);
    master_reset <= 0;
    repeat (4) @(posedge sys_clk);
    wb(0, 8'h58, 32'h0);
    check("period init", rd, `USG_PERIOD_RST);
    wb(0, 8'h7c, 32'h0);
    check("ctrl init", rd, 32'h1);
    check("oe init", strobe_oe, 32'h1);
    wb(0, 8'hc0, 32'h0);
    check("status init", rd[1:0], 2'b10);
    check("count init", rd[31:16], 32'h0);
    tally_and_finish();
  end
endmodule : tb

// File: tb/usg_host_model.sv
// host side of the update pin: raises it on request in external mode
`timescale 1ns/100ps
module usg_host_model (
  // clock
  input wire logic sys_clk,
  // pin as driven by the device
  input wire logic strobe_oe,
  input wire logic strobe_o,
  // request from the bench
  input wire logic [7:0] hold,
  input wire logic go,
  // resolved pin level
  output logic pin
);
  int cnt = 0;
  always @(posedge sys_clk) begin
    if (go) begin
      cnt <= hold;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // host drives only while the device lets go of the pin
  assign pin = strobe_oe ? strobe_o : (cnt > 0);
endmodule : usg_host_model
